// >>> verilog/vad_defs.vh
`ifndef VAD_DEFS_VH
`define VAD_DEFS_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define VAD_REG_MODE 8'h00
`define VAD_REG_SPREAD 8'h04
`define VAD_REG_PDEPTH 8'h08
`define VAD_REG_CDEPTH 8'h0C
`define VAD_REG_RATE 8'h10
`define VAD_REG_BUSY 8'h14
// ----------------------------------------
// Mode register fields and reset values
// ----------------------------------------
`define VAD_F_ALLOC 3:0
`define VAD_F_PRIO 5:4
`define VAD_F_TRIG 7:6
`define VAD_F_PHASE 8
`define VAD_MODE_RST 9'h000
`define VAD_SPREAD_RST 9'h000
`define VAD_SPREAD_MAX 9'h1F4
`define VAD_DEPTH_RST 8'h00
`define VAD_RATE_RST 8'h00
// ----------------------------------------
// Allocation modes
// ----------------------------------------
`define VAD_M_POLY 4'h0
`define VAD_M_UNI2 4'h1
`define VAD_M_UNI3 4'h2
`define VAD_M_UNI4 4'h3
`define VAD_M_UNI6 4'h4
`define VAD_M_UNI12 4'h5
`define VAD_M_MONO 4'h6
`define VAD_M_MONO2 4'h7
`define VAD_M_MONO3 4'h8
`define VAD_M_MONO4 4'h9
`define VAD_M_MONO6 4'hA
`define VAD_M_POLY6 4'hB
`define VAD_M_POLY8 4'hC
// ----------------------------------------
// Priority and envelope start policies
// ----------------------------------------
`define VAD_P_LAST 2'h0
`define VAD_P_LOW 2'h1
`define VAD_P_HIGH 2'h2
`define VAD_T_MONO 2'h0
`define VAD_T_RETRIG 2'h1
`define VAD_T_LEGATO 2'h2
`define VAD_T_ONESHOT 2'h3
// ----------------------------------------
// Timing
// ----------------------------------------
`define VAD_CLK_NS 10
`define VAD_MS_NS 1000000
`define VAD_MS_CYCLES (`VAD_MS_NS / `VAD_CLK_NS)
`define VAD_BASE_MIN_MS 12'd25
`define VAD_BASE_MAX_MS 12'd2500
`define VAD_RATE_MAX 20'd255
`endif

// >>> verilog/vad_wander.v
`timescale 1ns/1ps
`include "vad_defs.vh"
module vad_wander #(
	parameter LANES = 1,
	parameter [31:0] SEED = 32'h00000001
) (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Timing and depth
	input wire msTick,
	input wire [11:0] baseMs,
	input wire [7:0] depth,
	// Scaled offsets, one signed byte per lane
	output reg [LANES*8-1:0] wander_ff
);
	reg [31:0] rng_ff;
	reg [LANES*8-1:0] pool_ff;
	reg [LANES*8-1:0] target_ff;
	reg [12:0] count_ff;
	wire [31:0] xa = rng_ff ^ (rng_ff << 13);
	wire [31:0] xb = xa ^ (xa >> 17);
	wire [31:0] nxt_rng = xb ^ (xb << 5);
	wire [LANES*8+7:0] shifted = {pool_ff, rng_ff[7:0]};
	wire [19:0] stretch = baseMs * rng_ff[15:8];
	wire [12:0] nxt_count = {1'b0, baseMs} + {1'b0, stretch[19:8]};
	// ----------------------------------------
	// Random interval and target
	// ----------------------------------------
	always @(posedge mclk) begin
		if (rst) begin
			rng_ff <= SEED;
			pool_ff <= {LANES*8{1'b0}};
			target_ff <= {LANES*8{1'b0}};
			count_ff <= 13'h0000;
		end else begin
			rng_ff <= nxt_rng;
			pool_ff <= shifted[LANES*8-1:0];
			if (msTick) begin
				if (count_ff == 13'h0000) begin
					// Interval is base times one to two
					count_ff <= nxt_count;
					target_ff <= pool_ff;
				end else begin
					count_ff <= count_ff - 13'h0001;
				end
			end
		end
	end
	// ----------------------------------------
	// Depth scaling per lane
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < LANES; i = i + 1) begin : gLane
			wire signed [16:0] prod = $signed(target_ff[i*8+7:i*8]) * $signed({1'b0, depth});
			always @(posedge mclk) begin
				if (rst) begin
					wander_ff[i*8+7:i*8] <= 8'h00;
				end else begin
					wander_ff[i*8+7:i*8] <= prod[15:8];
				end
			end
		end
	endgenerate
endmodule

// >>> verilog/vad_voice_alloc.v
`timescale 1ns/1ps
`include "vad_defs.vh"
module vad_voice_alloc #(
	parameter MS_CYCLES = `VAD_MS_CYCLES
) (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Wishbone slave
	input wire cyc_i,
	input wire stb_i,
	input wire we_i,
	input wire [7:0] adr_i,
	input wire [3:0] sel_i,
	input wire [31:0] dat_i,
	output reg [31:0] dat_o,
	output reg ack_o,
	// Note events
	input wire evValid,
	input wire evOn,
	input wire [6:0] evNote,
	output reg evReady_ff,
	// Voice control
	output reg [11:0] voiceGate_ff,
	output reg [83:0] voiceNote_ff,
	output reg [167:0] voiceDetune_ff,
	output reg [11:0] voiceAttack_ff,
	output reg [11:0] voiceZero_ff,
	output reg [11:0] phaseRestart_ff,
	output reg envNoSustain_ff,
	// Wander offsets
	output wire [95:0] pitchWander,
	output wire [959:0] controlWander
);
	// ----------------------------------------
	// Mode tables
	// ----------------------------------------
	function [3:0] stackOf(input [3:0] m);
		begin
			case (m)
				`VAD_M_UNI2, `VAD_M_MONO2: stackOf = 4'h2;
				`VAD_M_UNI3, `VAD_M_MONO3: stackOf = 4'h3;
				`VAD_M_UNI4, `VAD_M_MONO4: stackOf = 4'h4;
				`VAD_M_UNI6, `VAD_M_MONO6: stackOf = 4'h6;
				`VAD_M_UNI12: stackOf = 4'hC;
				default: stackOf = 4'h1;
			endcase
		end
	endfunction
	function [3:0] capOf(input [3:0] m);
		begin
			case (m)
				`VAD_M_UNI2: capOf = 4'h6;
				`VAD_M_UNI3: capOf = 4'h4;
				`VAD_M_UNI4: capOf = 4'h3;
				`VAD_M_UNI6: capOf = 4'h2;
				`VAD_M_UNI12, `VAD_M_MONO, `VAD_M_MONO2, `VAD_M_MONO3, `VAD_M_MONO4, `VAD_M_MONO6: capOf = 4'h1;
				`VAD_M_POLY6: capOf = 4'h6;
				`VAD_M_POLY8: capOf = 4'h8;
				default: capOf = 4'hC;
			endcase
		end
	endfunction
	function [3:0] groupOf(input [3:0] v, input [3:0] s);
		begin
			case (s)
				4'h2: groupOf = v >> 1;
				4'h3: groupOf = v / 4'h3;
				4'h4: groupOf = v >> 2;
				4'h6: groupOf = v / 4'h6;
				4'hC: groupOf = 4'h0;
				default: groupOf = v;
			endcase
		end
	endfunction
	// Offset in tenths of a cent; position 2k-(S-1) is never zero for even S
	function [13:0] detOf(input [3:0] k, input [3:0] s, input [8:0] sp);
		reg signed [5:0] pos;
		reg signed [14:0] prod;
		reg signed [14:0] q;
		begin
			pos = $signed({1'b0, k, 1'b0}) - $signed({2'b00, s}) + 6'sd1;
			prod = $signed({1'b0, sp}) * pos;
			case (s)
				4'h2: q = prod;
				4'h3: q = prod / 15'sd2;
				4'h4: q = prod / 15'sd3;
				4'h6: q = prod / 15'sd5;
				4'hC: q = prod / 15'sd11;
				default: q = 15'sd0;
			endcase
			detOf = q[13:0];
		end
	endfunction
	// ----------------------------------------
	// Registers over Wishbone
	// ----------------------------------------
	reg [8:0] mode_ff;
	reg [8:0] spread_ff;
	reg [7:0] pDepth_ff;
	reg [7:0] cDepth_ff;
	reg [7:0] rate_ff;
	reg modeWrite_ff;
	wire wbReq = cyc_i & stb_i & ~ack_o;
	wire wbWr = cyc_i & stb_i & we_i & ack_o; // Write lands on the edge where the master sees ack
	wire [3:0] allocMode = mode_ff[`VAD_F_ALLOC];
	wire [1:0] prio = mode_ff[`VAD_F_PRIO];
	wire [1:0] trig = mode_ff[`VAD_F_TRIG];
	wire [8:0] spreadIn = {sel_i[1] ? dat_i[8] : spread_ff[8], sel_i[0] ? dat_i[7:0] : spread_ff[7:0]};
	always @(posedge mclk) begin
		if (rst) begin
			mode_ff <= `VAD_MODE_RST;
			spread_ff <= `VAD_SPREAD_RST;
			pDepth_ff <= `VAD_DEPTH_RST;
			cDepth_ff <= `VAD_DEPTH_RST;
			rate_ff <= `VAD_RATE_RST;
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
			modeWrite_ff <= 1'b0;
		end else begin
			ack_o <= wbReq;
			modeWrite_ff <= 1'b0;
			dat_o <= 32'h00000000;
			if (wbWr) begin
				case (adr_i)
					`VAD_REG_MODE: begin
						if (sel_i[0]) mode_ff[7:0] <= dat_i[7:0];
						if (sel_i[1]) mode_ff[8] <= dat_i[8];
						modeWrite_ff <= |sel_i[1:0];
					end
					// One stored value serves both fader and menu; clamp at 50.0
					`VAD_REG_SPREAD: spread_ff <= (spreadIn > `VAD_SPREAD_MAX) ? `VAD_SPREAD_MAX : spreadIn;
					`VAD_REG_PDEPTH: if (sel_i[0]) pDepth_ff <= dat_i[7:0];
					`VAD_REG_CDEPTH: if (sel_i[0]) cDepth_ff <= dat_i[7:0];
					`VAD_REG_RATE: if (sel_i[0]) rate_ff <= dat_i[7:0];
					default: ;
				endcase
			end else if (wbReq & ~we_i) begin
				case (adr_i)
					`VAD_REG_MODE: dat_o <= {23'h000000, mode_ff};
					`VAD_REG_SPREAD: dat_o <= {23'h000000, spread_ff};
					`VAD_REG_PDEPTH: dat_o <= {24'h000000, pDepth_ff};
					`VAD_REG_CDEPTH: dat_o <= {24'h000000, cDepth_ff};
					`VAD_REG_RATE: dat_o <= {24'h000000, rate_ff};
					`VAD_REG_BUSY: dat_o <= {20'h00000, voiceGate_ff};
					default: dat_o <= 32'h00000000;
				endcase
			end
		end
	end
	// ----------------------------------------
	// Group state and allocation choice
	// ----------------------------------------
	reg [11:0] busy_ff;
	reg [6:0] noteG_ff [0:11];
	reg [3:0] age_ff [0:11];
	wire [3:0] stack = stackOf(allocMode);
	wire [3:0] cap = capOf(allocMode);
	wire accept = evValid & evReady_ff;
	reg take;
	reg [3:0] tgt;
	reg wasBusy;
	reg offHit;
	reg [3:0] offG;
	reg freeHit;
	reg [3:0] freeG;
	reg [3:0] hiG;
	reg [3:0] loG;
	reg [3:0] oldG;
	reg [6:0] hiN;
	reg [6:0] loN;
	reg [3:0] oldA;
	integer g, h;
	always @* begin
		freeHit = 1'b0;
		freeG = 4'h0;
		offHit = 1'b0;
		offG = 4'h0;
		hiG = 4'h0;
		loG = 4'h0;
		oldG = 4'h0;
		hiN = 7'h00;
		loN = 7'h7F;
		oldA = 4'h0;
		for (g = 0; g < 12; g = g + 1) begin
			if (g < cap) begin
				if (!busy_ff[g] && !freeHit) begin
					freeHit = 1'b1;
					freeG = g[3:0];
				end
				if (busy_ff[g]) begin
					if (noteG_ff[g] >= hiN) begin
						hiN = noteG_ff[g];
						hiG = g[3:0];
					end
					if (noteG_ff[g] <= loN) begin
						loN = noteG_ff[g];
						loG = g[3:0];
					end
					if (age_ff[g] >= oldA) begin
						oldA = age_ff[g];
						oldG = g[3:0];
					end
					if (noteG_ff[g] == evNote && !offHit) begin
						offHit = 1'b1;
						offG = g[3:0];
					end
				end
			end
		end
		// Free groups first; stealing only when mono or out of voices
		take = 1'b0;
		tgt = freeG;
		if (freeHit) begin
			take = 1'b1;
		end else begin
			case (prio)
				`VAD_P_LOW: begin
					take = evNote < loN;
					tgt = hiG;
				end
				`VAD_P_HIGH: begin
					take = evNote > hiN;
					tgt = loG;
				end
				default: begin
					take = 1'b1;
					tgt = oldG;
				end
			endcase
		end
		wasBusy = busy_ff[tgt];
	end
	wire doOn = accept & evOn & take;
	wire doOff = accept & ~evOn & offHit;
	// Legato keeps a busy group's envelope running
	wire fire = ~(trig == `VAD_T_LEGATO && wasBusy);
	wire zero = (trig == `VAD_T_RETRIG) | (trig == `VAD_T_ONESHOT);
	always @(posedge mclk) begin
		if (rst) begin
			busy_ff <= 12'h000;
			evReady_ff <= 1'b0;
			envNoSustain_ff <= 1'b0;
			for (h = 0; h < 12; h = h + 1) begin
				noteG_ff[h] <= 7'h00;
				age_ff[h] <= 4'h0;
			end
		end else begin
			evReady_ff <= 1'b1;
			envNoSustain_ff <= (trig == `VAD_T_ONESHOT);
			if (modeWrite_ff) begin
				// Regrouping voices invalidates every held note
				busy_ff <= 12'h000;
			end else if (doOn) begin
				busy_ff[tgt] <= 1'b1;
				noteG_ff[tgt] <= evNote;
				for (h = 0; h < 12; h = h + 1) begin
					if (h == tgt) begin
						age_ff[h] <= 4'h0;
					end else if (age_ff[h] != 4'hF) begin
						age_ff[h] <= age_ff[h] + 4'h1;
					end
				end
			end else if (doOff) begin
				busy_ff[offG] <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// Per-voice outputs
	// ----------------------------------------
	genvar v;
	generate
		for (v = 0; v < 12; v = v + 1) begin : gVoice
			localparam [31:0] VIDX = v;
			// Mono modes have cap 1, so only group 0 is ever chosen
			wire [3:0] grp = groupOf(VIDX[3:0], stack);
			wire inUse = grp < cap;
			wire [7:0] base8 = grp * stack;
			wire [3:0] pos = VIDX[3:0] - base8[3:0];
			always @(posedge mclk) begin
				if (rst) begin
					voiceGate_ff[v] <= 1'b0;
					voiceNote_ff[v*7+6:v*7] <= 7'h00;
					voiceDetune_ff[v*14+13:v*14] <= 14'h0000;
					voiceAttack_ff[v] <= 1'b0;
					voiceZero_ff[v] <= 1'b0;
					phaseRestart_ff[v] <= 1'b0;
				end else begin
					voiceAttack_ff[v] <= 1'b0;
					voiceZero_ff[v] <= 1'b0;
					phaseRestart_ff[v] <= 1'b0;
					if (modeWrite_ff) begin
						voiceGate_ff[v] <= 1'b0;
					end else if (doOn && inUse && grp == tgt) begin
						voiceGate_ff[v] <= 1'b1;
						voiceNote_ff[v*7+6:v*7] <= evNote;
						voiceDetune_ff[v*14+13:v*14] <= detOf(pos, stack, spread_ff);
						voiceAttack_ff[v] <= fire;
						voiceZero_ff[v] <= fire & zero;
						phaseRestart_ff[v] <= fire & mode_ff[`VAD_F_PHASE];
					end else if (doOff && grp == offG) begin
						voiceGate_ff[v] <= 1'b0;
					end
				end
			end
		end
	endgenerate
	// ----------------------------------------
	// Wander timebase and generators
	// ----------------------------------------
	reg [19:0] msCnt_ff;
	reg msTick_ff;
	reg [11:0] baseMs_ff;
	wire [19:0] spanMul = rate_ff * (`VAD_BASE_MAX_MS - `VAD_BASE_MIN_MS);
	wire [19:0] spanQ = spanMul / `VAD_RATE_MAX;
	always @(posedge mclk) begin
		if (rst) begin
			msCnt_ff <= 20'h00000;
			msTick_ff <= 1'b0;
			baseMs_ff <= `VAD_BASE_MIN_MS;
		end else begin
			msTick_ff <= (msCnt_ff == MS_CYCLES - 1);
			msCnt_ff <= (msCnt_ff == MS_CYCLES - 1) ? 20'h00000 : msCnt_ff + 20'h00001;
			baseMs_ff <= `VAD_BASE_MIN_MS + spanQ[11:0];
		end
	end
	generate
		for (v = 0; v < 12; v = v + 1) begin : gWander
			// Distinct seeds keep every voice on its own sequence
			vad_wander #(.LANES(1), .SEED(32'h9E3779B9 ^ (v * 32'h01010101))) uPitch (
				.mclk(mclk),
				.rst(rst),
				.msTick(msTick_ff),
				.baseMs(baseMs_ff),
				.depth(pDepth_ff),
				.wander_ff(pitchWander[v*8+7:v*8])
			);
			vad_wander #(.LANES(10), .SEED(32'h7F4A7C15 ^ (v * 32'h00F0F0F1))) uCtrl (
				.mclk(mclk),
				.rst(rst),
				.msTick(msTick_ff),
				.baseMs(baseMs_ff),
				.depth(cDepth_ff),
				.wander_ff(controlWander[v*80+79:v*80])
			);
		end
	endgenerate
endmodule

// >>> sim/vad_alloc_monitor.sv
`timescale 1ns/1ps
module vad_alloc_monitor (
	// Clock and reset
	input wire mclk,
	input wire rst,
	// Bus handshake
	input wire cyc_i,
	input wire stb_i,
	input wire ack_o,
	// Note events
	input wire evValid,
	input wire evOn,
	input wire evReady_ff,
	// Voice control
	input wire [11:0] voiceGate_ff,
	input wire [11:0] voiceAttack_ff,
	input wire [11:0] voiceZero_ff,
	input wire [11:0] phaseRestart_ff
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	property p_ack_next; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
	property p_ack_pulse; ack_o |=> !ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	// ----------------------------------------
	// Voice control
	// ----------------------------------------
	property p_ready; !rst |=> evReady_ff; endproperty
	a_ready: assert property (p_ready) else $error("event ready low after reset");
	property p_zero_att; (voiceZero_ff & ~voiceAttack_ff) == 12'h000; endproperty
	a_zero_att: assert property (p_zero_att) else $error("zero pulse without attack");
	property p_phase_att; (phaseRestart_ff & ~voiceAttack_ff) == 12'h000; endproperty
	a_phase_att: assert property (p_phase_att) else $error("phase restart without attack");
	property p_att_gate; (voiceAttack_ff & ~voiceGate_ff) == 12'h000; endproperty
	a_att_gate: assert property (p_att_gate) else $error("attack on idle voice");
	// Off events only ever free voices
	property p_off; evValid && evReady_ff && !evOn |=> (voiceGate_ff & ~$past(voiceGate_ff)) == 12'h000; endproperty
	a_off: assert property (p_off) else $error("gate rose on note off");
	property p_rise_att; ((voiceGate_ff & ~$past(voiceGate_ff)) & ~voiceAttack_ff) == 12'h000; endproperty
	a_rise_att: assert property (p_rise_att) else $error("new gate without attack");
	property p_rise_on;
		(voiceGate_ff & ~$past(voiceGate_ff)) != 12'h000 |-> $past(evValid) && $past(evOn) && $past(evReady_ff);
	endproperty
	a_rise_on: assert property (p_rise_on) else $error("gate rose without note on");
endmodule
bind vad_voice_alloc vad_alloc_monitor vad_alloc_monitor_i (.mclk(mclk), .rst(rst), .cyc_i(cyc_i),
	.stb_i(stb_i), .ack_o(ack_o), .evValid(evValid), .evOn(evOn), .evReady_ff(evReady_ff),
	.voiceGate_ff(voiceGate_ff), .voiceAttack_ff(voiceAttack_ff), .voiceZero_ff(voiceZero_ff),
	.phaseRestart_ff(phaseRestart_ff));

// >>> sim/vad_note_src.sv
`timescale 1ns/1ps
module vad_note_src (
	// Clock and handshake
	input wire mclk,
	input wire evReady_ff,
	// Note event
	output logic evValid,
	output logic evOn,
	output logic [6:0] evNote
);
	initial begin
		evValid = 1'b0;
		evOn = 1'b0;
		evNote = 7'h00;
	end
	// Stale data is inverted after acceptance so a held value is never mistaken for a new event
	task automatic send(input logic on, input logic [6:0] n, input int idle);
		repeat (idle) @(posedge mclk);
		@(posedge mclk);
		evValid <= 1'b1;
		evOn <= on;
		evNote <= n;
		do @(posedge mclk); while (evReady_ff !== 1'b1);
		evValid <= 1'b0;
		evOn <= ~on;
		evNote <= ~n;
	endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
`include "vad_defs.vh"
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("unexpected %s: expected %0h seen %0h", nm, e, a); end end
module tb_top;
	logic mclk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ackO, evValid, evOn, evReady, noSus;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0, datO, rd;
	logic [6:0] evNote;
	logic [11:0] gate, att, zero, phase;
	logic [83:0] note;
	logic [167:0] det;
	logic [95:0] pw;
	logic [959:0] cw;
	int num_errors = 0, n_checks = 0;
	initial forever #5 mclk = ~mclk;
	vad_voice_alloc #(.MS_CYCLES(10)) vad_voice_alloc_i (.mclk(mclk), .rst(rst), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(datO), .ack_o(ackO), .evValid(evValid),
		.evOn(evOn), .evNote(evNote), .evReady_ff(evReady), .voiceGate_ff(gate), .voiceNote_ff(note),
		.voiceDetune_ff(det), .voiceAttack_ff(att), .voiceZero_ff(zero), .phaseRestart_ff(phase),
		.envNoSustain_ff(noSus), .pitchWander(pw), .controlWander(cw));
	vad_note_src vad_note_src_i (.mclk(mclk), .evReady_ff(evReady), .evValid(evValid), .evOn(evOn),
		.evNote(evNote));
	// ----------------------------------------
	// Bus and event helpers
	// ----------------------------------------
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do @(posedge mclk); while (ackO !== 1'b1);
		rd = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Mode writes free all voices a cycle late, so events wait a little
	task automatic setm(input logic [31:0] m);
		wb(1'b1, `VAD_REG_MODE, m);
		repeat (3) @(posedge mclk);
	endtask
	// Odd note numbers are presented slowly
	task automatic ev(input logic o, input logic [6:0] n);
		vad_note_src_i.send(o, n, int'(n[0]));
		#1;
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_regs;
		for (int a = 0; a <= 20; a += 4) begin
			wb(1'b0, a[7:0], 32'h0);
			`CHK("reset reg", 32'h0, rd)
		end
		`CHK("pitch wander", 96'h0, pw)
		wb(1'b1, `VAD_REG_SPREAD, 32'h3FF);
		wb(1'b0, `VAD_REG_SPREAD, 32'h0);
		`CHK("spread clamp", 32'h1F4, rd)
		wb(1'b1, `VAD_REG_BUSY, 32'hFFF);
		wb(1'b0, `VAD_REG_BUSY, 32'h0);
		`CHK("busy", 32'h0, rd)
		wb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rd)
	endtask
	task automatic t_stack;
		int s;
		int sz[10] = '{2, 3, 4, 6, 12, 1, 2, 3, 4, 6};
		for (int i = 0; i < 10; i++) begin
			s = sz[i];
			setm(32'(i + 1));
			ev(1'b1, 7'd60);
			`CHK("stack gate", 12'((1 << s) - 1), gate)
			for (int k = 0; k < s && s > 1; k++)
				`CHK("detune", 14'(500 * (2 * k - s + 1) / (s - 1)), det[14 * k +: 14])
			ev(1'b1, 7'd64);
			`CHK("second gate", 12'((1 << (i > 3 ? s : 2 * s)) - 1), gate)
			`CHK("voice0 note", i > 3 ? 7'd64 : 7'd60, note[6:0])
		end
	endtask
	task automatic t_cap;
		int cap[3] = '{12, 6, 8};
		logic [3:0] md[3] = '{`VAD_M_POLY, `VAD_M_POLY6, `VAD_M_POLY8};
		for (int i = 0; i < 3; i++) begin
			setm({28'h0, md[i]});
			for (int n = 0; n <= cap[i]; n++)
				ev(1'b1, 7'(40 + n));
			`CHK("cap gate", 12'((1 << cap[i]) - 1), gate)
			`CHK("stolen note", 7'(40 + cap[i]), note[6:0])
			ev(1'b0, 7'd41);
			wb(1'b0, `VAD_REG_BUSY, 32'h0);
			`CHK("busy after off", 32'((1 << cap[i]) - 3), rd)
		end
	endtask
	task automatic t_prio;
		for (int p = 1; p <= 2; p++) begin
			setm({26'h0, p[1:0], `VAD_M_MONO});
			ev(1'b1, 7'd60);
			ev(1'b1, p == 1 ? 7'd70 : 7'd50);
			`CHK("refused", 7'd60, note[6:0])
			ev(1'b1, p == 1 ? 7'd50 : 7'd70);
			`CHK("taken", p == 1 ? 7'd50 : 7'd70, note[6:0])
		end
	endtask
	task automatic t_trig;
		for (int t = 0; t < 4; t++) if (t != 2) begin
			setm({23'h0, 1'b1, t[1:0], 6'h00});
			ev(1'b1, 7'd60);
			`CHK("attack", 12'h001, att)
			`CHK("zero", t == 0 ? 12'h000 : 12'h001, zero)
			`CHK("phase", 12'h001, phase)
			`CHK("no sustain", t == 3, noSus)
		end
		setm({24'h0, `VAD_T_LEGATO, `VAD_P_LAST, `VAD_M_MONO});
		ev(1'b1, 7'd60);
		`CHK("legato first", 12'h001, att)
		ev(1'b1, 7'd62);
		`CHK("legato held", 12'h000, att)
		ev(1'b0, 7'd62);
		`CHK("legato off", 12'h000, gate)
		ev(1'b1, 7'd64);
		`CHK("legato again", 12'h001, att)
	endtask
	task automatic t_wander;
		int n;
		logic [7:0] v;
		wb(1'b1, `VAD_REG_PDEPTH, 32'hFF);
		wb(1'b1, `VAD_REG_CDEPTH, 32'hFF);
		wb(1'b1, `VAD_REG_RATE, 32'h0);
		// The first change may be a partial interval
		for (int j = 0; j < 3; j++) begin
			v = pw[7:0];
			n = 0;
			while (pw[7:0] === v && n < 1000) begin
				@(posedge mclk);
				n++;
			end
		end
		`CHK("interval", 1'b1, n >= 250 && n <= 500)
		`CHK("pitch drift", 1'b1, pw !== 96'h0)
		`CHK("voices differ", 1'b1, pw[7:0] !== pw[15:8])
		`CHK("control drift", 1'b1, cw !== 960'h0)
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		t_regs;
		t_stack;
		t_cap;
		t_prio;
		t_trig;
		t_wander;
		give_verdict;
	end
	initial begin
		repeat (30000) @(posedge mclk);
		num_errors++;
		give_verdict;
	end
endmodule
